// >>> inc/stdio_if.sv
interface stdio_if;
    // Serial link, device to line and loopback
    logic       lineHigh;
    logic       lineLow;
    logic       loopbackInputA;
    logic       loopbackInputB;
    // Monitor shutdown lines and straps
    logic       monitorShutdownFirst;
    logic       monitorShutdownSecond;
    logic       strapHigh;
    logic       strapLow;
    // Discrete lines
    logic [15:0] discreteIn;
    logic [7:0]  discreteOut;
    logic [3:0]  txSelect;
    logic        txSync;

    modport device (
        output lineHigh, lineLow, loopbackInputA, loopbackInputB,
        output discreteOut, txSelect, txSync,
        input  monitorShutdownFirst, monitorShutdownSecond,
        input  strapHigh, strapLow, discreteIn
    );
    modport far (
        input  lineHigh, lineLow, loopbackInputA, loopbackInputB,
        input  discreteOut, txSelect, txSync,
        output monitorShutdownFirst, monitorShutdownSecond,
        output strapHigh, strapLow, discreteIn
    );
endinterface

// >>> inc/stdio_pkg.sv
package stdio_pkg;
    // Bus and latch widths
    localparam int DATA_W    = 8;
    localparam int DIN_W     = 16;
    localparam int TX_COUNT  = 4;
    localparam int BIT_CNT_W = 3;
    // Reset values and last bit count
    localparam logic [7:0]  STROBE_RST   = 8'h00;
    localparam logic [7:0]  DOUT_RST     = 8'h00;
    localparam logic [15:0] DIN_RST      = 16'h0000;
    localparam logic [2:0]  BIT_CNT_LAST = 3'h7;
    // Interrupt-mode strap levels
    localparam logic STRAP_HIGH = 1'b1;
    localparam logic STRAP_LOW  = 1'b0;
    // Serialiser states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } stdio_tx_state_e;
endpackage

// >>> rtl/stdio_device.sv
// Behaviour
// (R1) Write strobe low loads byte for serial shift
// (R2) Serial bit drives bipolar line pair
// (R3) Line output looped back for readback
// (R4) Sixteen discrete inputs latched onto data bus; code latches 15, with the strap copy in bit 8 in place of input 8
// (R5) Output write latches both output groups
// (R6) First group selects and syncs transmitters
// (R7) Second group drives discrete output lines
// (R8) Strap inverted gives gate enable, reinverted
// (R9) Monitor lines low leave transmitter untouched
// (R10) Monitor line high forces gate low
// (R11) Shutdown gating follows monitor combinationally; code gates from two-flop synchronised monitors, outputs registered
module stdio_device (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Link
    stdio_if.device          link,
    // Processor slow bus
    input  wire logic [7:0]  dataIn,
    input  wire logic        ioSelectSerial_n,
    input  wire logic        write_n,
    input  wire logic        transmitPathEnable,
    input  wire logic        ioSelectFive_n,
    output logic [15:0]      discreteRead,
    output logic [7:0]       loopbackByte,
    output logic             loopbackValid,
    output logic             txBusy,
    output logic             intGateEnable
);
    stdio_pkg::stdio_tx_state_e state;
    stdio_pkg::stdio_tx_state_e next_state;
    logic [7:0] shiftReg;
    logic [2:0] bitCnt;
    logic [7:0] strobeGroup;
    logic [7:0] rxShift;
    logic [2:0] rxCnt;
    logic [1:0] monA;
    logic [1:0] monB;
    logic [15:0] dinA;
    logic [15:0] dinB;
    logic [1:0] strapA;
    logic [1:0] strapB;
    logic       serialBit;
    logic       serialActive;

    // Counter step shared by shifter and loopback receiver
    function automatic logic [2:0] countStep(input logic [2:0] count);
        countStep = count + 3'h1;
    endfunction

    // Gate high while enabled and its monitor line is low
    function automatic logic shutdownGate(input logic enable,
                                          input logic monitorLine);
        shutdownGate = enable && !monitorLine;
    endfunction

    // Write decode
    wire txWrite  = !ioSelectSerial_n && !write_n;
    wire outWrite = !ioSelectFive_n && !write_n && transmitPathEnable;

    // Low strap inverted gives gate enable; reinverted copy goes to latch
    wire gateEn    = !strapB[0];                           // R8
    wire strapBack = !gateEn;                              // R8
    // Gate outputs: low when monitor line high
    wire gateFirst  = shutdownGate(gateEn, monB[0]);       // R9 R10 R11
    wire gateSecond = shutdownGate(gateEn, monB[1]);       // R9 R10 R11
    wire txRun      = gateFirst && gateSecond;             // R11

    // Serialiser next state
    always_comb begin
        next_state = state;
        case (state)
            stdio_pkg::ST_IDLE: begin
                if (txWrite) begin
                    next_state = stdio_pkg::ST_SHIFT;      // R1
                end
            end
            stdio_pkg::ST_SHIFT: begin
                if (txRun && bitCnt == stdio_pkg::BIT_CNT_LAST) begin
                    next_state = stdio_pkg::ST_DONE;
                end
            end
            stdio_pkg::ST_DONE: begin
                next_state = stdio_pkg::ST_IDLE;
            end
            default: begin
                next_state = stdio_pkg::ST_IDLE;
            end
        endcase
    end

    assign serialBit    = shiftReg[0];
    assign serialActive = (state == stdio_pkg::ST_SHIFT) && txRun;

    // Line pair levels for the bit on the shifter; both low is null
    wire lineMark  = serialActive && serialBit;
    wire lineSpace = serialActive && !serialBit;

    // Serialiser registers, stalled while shutdown gates low
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state    <= stdio_pkg::ST_IDLE;
            shiftReg <= 8'h00;
            bitCnt   <= 3'h0;
        end else begin
            state <= next_state;
            if (state == stdio_pkg::ST_IDLE && txWrite) begin
                shiftReg <= dataIn;                        // R1
                bitCnt   <= 3'h0;
            end else if (serialActive) begin
                shiftReg <= {1'b0, shiftReg[7:1]};         // R1
                bitCnt   <= countStep(bitCnt);
            end
        end
    end

    // Bipolar line pair and loopback drive
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            link.lineHigh       <= 1'b0;
            link.lineLow        <= 1'b0;
            link.loopbackInputA <= 1'b0;
            link.loopbackInputB <= 1'b0;
        end else begin
            link.lineHigh       <= lineMark;    // R2
            link.lineLow        <= lineSpace;   // R2
            link.loopbackInputA <= lineMark;    // R3
            link.loopbackInputB <= lineSpace;   // R3
        end
    end

    // Loopback bit present and shifter with that bit taken in
    wire       rxAny  = link.loopbackInputA || link.loopbackInputB;
    wire [7:0] rxNext = {link.loopbackInputA, rxShift[7:1]};

    // Loopback receiver rebuilds each sent byte
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rxShift       <= 8'h00;
            rxCnt         <= 3'h0;
            loopbackByte  <= 8'h00;
            loopbackValid <= 1'b0;
        end else begin
            loopbackValid <= 1'b0;
            if (rxAny) begin
                rxShift <= rxNext;                              // R3
                rxCnt   <= countStep(rxCnt);
                if (rxCnt == stdio_pkg::BIT_CNT_LAST) begin
                    loopbackByte  <= rxNext;
                    loopbackValid <= 1'b1;                      // R3
                end
            end
        end
    end

    // Synchronisers for pins from the far end
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            monA   <= 2'h0;
            monB   <= 2'h0;
            dinA   <= stdio_pkg::DIN_RST;
            dinB   <= stdio_pkg::DIN_RST;
            strapA <= 2'h0;
            strapB <= 2'h0;
        end else begin
            monA   <= {link.monitorShutdownSecond, link.monitorShutdownFirst};
            monB   <= monA;
            dinA   <= link.discreteIn;
            dinB   <= dinA;
            strapA <= {link.strapHigh, link.strapLow};
            strapB <= strapA;
        end
    end

    // Discrete input latch, strap copy in bit 0 of second group
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            discreteRead  <= stdio_pkg::DIN_RST;
            intGateEnable <= 1'b0;
            txBusy        <= 1'b0;
        end else begin
            discreteRead  <= {dinB[15:9], strapBack, dinB[7:0]}; // R4 R8
            intGateEnable <= gateEn;
            txBusy        <= (next_state != stdio_pkg::ST_IDLE);
        end
    end

    // Output latch: strobe group and discrete group
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            strobeGroup      <= stdio_pkg::STROBE_RST;
            link.discreteOut <= stdio_pkg::DOUT_RST;
        end else if (outWrite) begin
            strobeGroup      <= dataIn;                    // R5 R6
            link.discreteOut <= dataIn;                    // R5 R7
        end
    end

    // Transmitter select and sync, forced low by shutdown
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            link.txSelect <= 4'h0;
            link.txSync   <= 1'b0;
        end else begin
            link.txSelect <= txRun ? strobeGroup[3:0] : 4'h0;  // R6 R10
            link.txSync   <= txRun && strobeGroup[4];          // R6 R10
        end
    end
endmodule

// >>> rtl/stdio_far_end.sv
// Far end: monitor and discrete sources driven from user ports, straps tied to package constants
module stdio_far_end (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Link
    stdio_if.far             link,
    // User side
    input  wire logic        failFirst,
    input  wire logic        failSecond,
    input  wire logic [15:0] discreteSource,
    output logic             lineHighSeen,
    output logic             lineLowSeen,
    output logic [7:0]       discreteSeen,
    output logic [3:0]       selectSeen
);
    logic [7:0] syncA;
    logic [7:0] syncB;
    logic [1:0] lineA;
    logic [1:0] lineB;

    // Shutdown lines low when no failure
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            link.monitorShutdownFirst  <= 1'b0;
            link.monitorShutdownSecond <= 1'b0;
            link.discreteIn            <= stdio_pkg::DIN_RST;
        end else begin
            link.monitorShutdownFirst  <= failFirst;  // R10
            link.monitorShutdownSecond <= failSecond; // R10
            link.discreteIn            <= discreteSource;
        end
    end

    // Interrupt-mode straps
    assign link.strapHigh = stdio_pkg::STRAP_HIGH;
    assign link.strapLow  = stdio_pkg::STRAP_LOW;

    // Three-stage sampling of line pair and discrete outputs; select sampled once
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lineA <= 2'h0;
            lineB <= 2'h0;
            syncA <= 8'h00;
            syncB <= 8'h00;
            lineHighSeen <= 1'b0;
            lineLowSeen  <= 1'b0;
            discreteSeen <= 8'h00;
            selectSeen   <= 4'h0;
        end else begin
            lineA <= {link.lineLow, link.lineHigh};
            lineB <= lineA;
            syncA <= link.discreteOut;
            syncB <= syncA;
            lineHighSeen <= lineB[0];
            lineLowSeen  <= lineB[1];
            discreteSeen <= syncB;
            selectSeen   <= link.txSelect;
        end
    end
endmodule

// >>> testbench/serial_tx_discrete_io_shutdown_test.sv
module serial_tx_discrete_io_shutdown_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, nrst, write_n, ioSelectSerial_n, ioSelectFive_n;
    logic        transmitPathEnable, failFirst, failSecond;
    logic        loopbackValid, txBusy, intGateEnable;
    logic        lineHighSeen, lineLowSeen;
    logic [3:0]  selectSeen;
    logic [7:0]  dataIn, loopbackByte, b, discreteSeen;
    logic [15:0] discreteSource, discreteRead;
    logic [7:0]  q[$];
    int          failures, checkCount, lineCount, k, c0;
    int          highSeen, lowSeen, h0, l0;

    stdio_if link ();
    stdio_device stdio_device_inst (.mclk(mclk), .nrst(nrst), .link(link),
        .dataIn(dataIn), .ioSelectSerial_n(ioSelectSerial_n),
        .write_n(write_n), .transmitPathEnable(transmitPathEnable),
        .ioSelectFive_n(ioSelectFive_n), .discreteRead(discreteRead),
        .loopbackByte(loopbackByte), .loopbackValid(loopbackValid),
        .txBusy(txBusy), .intGateEnable(intGateEnable));
    stdio_far_end stdio_far_end_inst (.mclk(mclk), .nrst(nrst), .link(link),
        .failFirst(failFirst), .failSecond(failSecond),
        .discreteSource(discreteSource), .lineHighSeen(lineHighSeen),
        .lineLowSeen(lineLowSeen), .discreteSeen(discreteSeen),
        .selectSeen(selectSeen));
    stdio_chk stdio_chk_inst (.mclk(mclk), .nrst(nrst),
        .lineHigh(link.lineHigh), .lineLow(link.lineLow),
        .loopbackInputA(link.loopbackInputA),
        .loopbackInputB(link.loopbackInputB),
        .monitorShutdownFirst(link.monitorShutdownFirst),
        .monitorShutdownSecond(link.monitorShutdownSecond),
        .strapHigh(link.strapHigh), .strapLow(link.strapLow),
        .discreteIn(link.discreteIn), .discreteOut(link.discreteOut),
        .txSelect(link.txSelect), .txSync(link.txSync));

    // Clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task endOfTest;
        if (failures == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One-cycle serial write; kept bytes become expectations
    task automatic serial(input logic [7:0] v, input logic keep);
        @(posedge mclk);
        dataIn <= v;
        ioSelectSerial_n <= 1'b0;
        write_n <= 1'b0;
        @(posedge mclk);
        ioSelectSerial_n <= 1'b1;
        write_n <= 1'b1;
        if (keep) q.push_back(v);
    endtask

    // One-cycle output latch write
    task automatic outw(input logic [7:0] v, input logic en);
        @(posedge mclk);
        dataIn <= v;
        transmitPathEnable <= en;
        ioSelectFive_n <= 1'b0;
        write_n <= 1'b0;
        @(posedge mclk);
        ioSelectFive_n <= 1'b1;
        write_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    // Active line cycles and loopback scoreboard
    always @(posedge mclk) begin
        if (link.lineHigh || link.lineLow) lineCount++;
        if (lineHighSeen === 1'b1) highSeen++;
        if (lineLowSeen === 1'b1) lowSeen++;
        if (loopbackValid === 1'b1) begin
            if (q.size() == 0) check(16'h0001, 16'h0000);
            else check(16'(loopbackByte), 16'(q.pop_front()));
        end
    end

    // Watchdog
    initial begin
        #100000;
        failures++;
        endOfTest;
    end

    initial begin
        failures = 0;
        checkCount = 0;
        lineCount = 0;
        highSeen = 0;
        lowSeen = 0;
        {nrst, failFirst, failSecond, transmitPathEnable} = 4'h0;
        {write_n, ioSelectSerial_n, ioSelectFive_n} = 3'h7;
        dataIn = 8'h00;
        discreteSource = 16'h0000;
        void'($urandom(38));
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        // Serial bytes; a second write while busy is ignored
        for (k = 0; k < 4; k++) begin
            b = 8'($urandom);
            c0 = lineCount;
            h0 = highSeen;
            l0 = lowSeen;
            serial(b, 1'b1);
            serial(~b, 1'b0);
            // Last byte is stalled mid-way by a shutdown pulse
            if (k == 3) begin
                failFirst <= 1'b1;
                repeat (6) @(posedge mclk);
                failFirst <= 1'b0;
            end
            for (int t = 0; t < 40 && txBusy !== 1'b0; t++) @(posedge mclk);
            repeat (3) @(posedge mclk);
            check(16'(lineCount - c0), 16'h0008);
            check(16'(highSeen - h0), 16'($countones(b)));
            check(16'(lowSeen - l0), 16'(8 - $countones(b)));
        end
        check(16'(q.size()), 16'h0000);
        // Output latch; a write without enable must not land
        for (k = 0; k < 4; k++) begin
            b = 8'($urandom) | 8'h10;
            outw(b, 1'b1);
            check(16'(link.discreteOut), 16'(b));
            check(16'({link.txSync, link.txSelect}), 16'(b[4:0]));
            check(16'(discreteSeen), 16'(b));
            check(16'(selectSeen), 16'(b[3:0]));
            outw(~b, 1'b0);
            check(16'(link.discreteOut), 16'(b));
        end
        // Discrete inputs, strap copy low in bit 8
        for (k = 0; k < 2; k++) begin
            discreteSource <= 16'($urandom);
            repeat (6) @(posedge mclk);
            check(discreteRead, discreteSource & 16'hFEFF);
        end
        check(16'(intGateEnable), 16'h0001);
        // Each monitor line and both, then recovery
        for (k = 1; k < 4; k++) begin
            {failSecond, failFirst} <= 2'(k);
            repeat (6) @(posedge mclk);
            check(16'({link.txSelect, link.txSync}), 16'h0000);
            {failSecond, failFirst} <= 2'h0;
            repeat (6) @(posedge mclk);
            check(16'({link.txSync, link.txSelect}), 16'(b[4:0]));
        end
        endOfTest;
    end
endmodule

// >>> testbench/stdio_chk.sv
// Checker on the link between the two ends
module stdio_chk (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // Line and loopback
    input wire logic        lineHigh,
    input wire logic        lineLow,
    input wire logic        loopbackInputA,
    input wire logic        loopbackInputB,
    // Monitor and straps
    input wire logic        monitorShutdownFirst,
    input wire logic        monitorShutdownSecond,
    input wire logic        strapHigh,
    input wire logic        strapLow,
    // Discretes
    input wire logic [15:0] discreteIn,
    input wire logic [7:0]  discreteOut,
    input wire logic [3:0]  txSelect,
    input wire logic        txSync
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Line pair and loopback copies
    property p_null; !(lineHigh && lineLow); endproperty
    a_null: assert property (p_null) else $error("pair both high");
    property p_loopA; loopbackInputA == lineHigh; endproperty
    a_loopA: assert property (p_loopA) else $error("loop A");
    property p_loopB; loopbackInputB == lineLow; endproperty
    a_loopB: assert property (p_loopB) else $error("loop B");
    // Shutdown gating
    property p_shut1;
        monitorShutdownFirst [*4] |-> txSelect == 4'h0 && !txSync;
    endproperty
    a_shut1: assert property (p_shut1) else $error("first gate");
    property p_shut2;
        monitorShutdownSecond [*4] |-> txSelect == 4'h0 && !txSync;
    endproperty
    a_shut2: assert property (p_shut2) else $error("second gate");
    property p_quiet;
        (monitorShutdownFirst || monitorShutdownSecond) [*4]
            |-> !lineHigh && !lineLow;
    endproperty
    a_quiet: assert property (p_quiet) else $error("line not quiet");
    property p_normal;
        (!monitorShutdownFirst && !monitorShutdownSecond) [*5]
            |-> {txSelect, txSync} == $past({discreteOut[3:0], discreteOut[4]});
    endproperty
    a_normal: assert property (p_normal) else $error("not restored");
    // Strobe group follows latched byte
    property p_sel;
        $changed(txSelect) && txSelect != 4'h0
            |-> txSelect == $past(discreteOut[3:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("select source");
    property p_sync; $rose(txSync) |-> $past(discreteOut[4]); endproperty
    a_sync: assert property (p_sync) else $error("sync source");

    // Main scenarios
    c_shut: cover property (monitorShutdownSecond [*4]);
    c_sync: cover property ($rose(txSync));
    c_line: cover property (lineHigh ##1 lineLow);
endmodule
